// ---- logic/drc_refresh.sv ----
// Module: DRAM refresh timer, address counter, strobe and control register
// Notes on behaviour
// - Own interval timer inserts refresh cycles independently.
// - Refresh drives address A0-A7, strobe low.
// - 8-bit address advances per completed cycle.
// - Bit 7 enables refresh; reset sets it.
// - Bit 6 selects two or three clocks.
// - Wait input and wait generator ignored during refresh.
// - Reset default: every 248 clocks, 3 long.
// - No insertion in reset, bus release, wait.
// - Timer runs on during bus release.
// - Registers decode only when upper address zero.
// - Internal writes also run external, no waits.
// - Internal reads skip waits; only control register reads discard external data.
`timescale 1ns/1ps
module drc_refresh (
   input  wire logic        I_CLOCK,
   input  wire logic        I_SYS_RST,
   input  wire logic [15:0] I_IO_ADDR,
   input  wire logic        I_IO_WR,
   input  wire logic        I_IO_RD,
   input  wire logic [7:0]  I_IO_WDATA,
   input  wire logic [7:0]  I_EXT_RDATA,
   input  wire logic        I_BUS_IDLE,
   input  wire logic        I_WAIT_N,
   input  wire logic        I_BUS_HOLD_REQUEST_N,
   output logic [7:0]       O_IO_RDATA,
   output logic             O_IO_INTERNAL,
   output logic             O_IGNORE_WAITS,
   output logic [7:0]       O_RENEW_ADDR,
   output logic             O_RENEW_STROBE_N,
   output logic             O_RENEW_BUSY
);
   import drc_pkg::*;

   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   logic wait_s1_ff, wait_s2_ff, hold_s1_ff, hold_s2_ff;

   // Two stages before use; first stage feeds only the second
   always_ff @(posedge I_CLOCK) begin
      if (I_SYS_RST) begin
         wait_s1_ff <= 1'b1;
         wait_s2_ff <= 1'b1;
         hold_s1_ff <= 1'b1;
         hold_s2_ff <= 1'b1;
      end else begin
         wait_s1_ff <= I_WAIT_N;
         wait_s2_ff <= wait_s1_ff;
         hold_s1_ff <= I_BUS_HOLD_REQUEST_N;
         hold_s2_ff <= hold_s1_ff;
      end
   end

   // ----------------------------------------
   // Register access
   // ----------------------------------------
   function automatic logic is_internal(input logic [15:0] a);
      return (a[15:8] == 8'h00);
   endfunction

   logic [7:0] renew_ctrl_ff;
   logic       hit_ctrl;
   assign hit_ctrl = is_internal(I_IO_ADDR) && (I_IO_ADDR[7:0] == ADDR_RENEW_CONTROL);

   // Control register; reset enables refresh with the extra wait
   always_ff @(posedge I_CLOCK) begin
      if (I_SYS_RST) begin
         renew_ctrl_ff <= RESET_RENEW_CTRL;
      end else if (I_IO_WR && hit_ctrl) begin
         renew_ctrl_ff <= {I_IO_WDATA[7:6], 6'h00};
      end
   end

   // Read data: internal value wins, external byte discarded
   always_ff @(posedge I_CLOCK) begin
      if (I_SYS_RST) begin
         O_IO_RDATA <= 8'h00;
      end else if (I_IO_RD) begin
         O_IO_RDATA <= hit_ctrl ? renew_ctrl_ff : I_EXT_RDATA;
      end
   end

   // Internal accesses still go out, but with fixed internal timing
   always_ff @(posedge I_CLOCK) begin
      if (I_SYS_RST) begin
         O_IO_INTERNAL <= 1'b0;
      end else begin
         O_IO_INTERNAL <= (I_IO_WR || I_IO_RD) && is_internal(I_IO_ADDR);
      end
   end

   // ----------------------------------------
   // Interval timer and pending request
   // ----------------------------------------
   logic [7:0] timer_ff;
   logic       pending_ff;
   logic       tick;
   drc_state_t state_ff, nxt_state;
   assign tick = (timer_ff == RENEW_INTERVAL_CYC - 8'h01);

   // Free running, even while the bus is released
   always_ff @(posedge I_CLOCK) begin
      if (I_SYS_RST) begin
         timer_ff <= 8'h00;
      end else begin
         timer_ff <= tick ? 8'h00 : timer_ff + 8'h01;
      end
   end

   logic allow;
   // Suppressed during release and waits; reset is handled by the clear
   assign allow = renew_ctrl_ff[BIT_RENEW_ON] && hold_s2_ff && wait_s2_ff && I_BUS_IDLE;

   // Request held until a cycle can start; new tick beats the clear
   always_ff @(posedge I_CLOCK) begin
      if (I_SYS_RST) begin
         pending_ff <= 1'b0;
      end else if (tick && renew_ctrl_ff[BIT_RENEW_ON]) begin
         pending_ff <= 1'b1;
      end else if (!renew_ctrl_ff[BIT_RENEW_ON]) begin
         pending_ff <= 1'b0;
      end else if (state_ff == DRC_IDLE && allow) begin
         pending_ff <= 1'b0;
      end
   end

   // ----------------------------------------
   // Refresh cycle sequencer
   // ----------------------------------------
   // Waits do not stretch a started cycle
   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         DRC_IDLE: if (pending_ff && allow) nxt_state = DRC_T1;
         DRC_T1:   nxt_state = DRC_T2;
         DRC_T2:   nxt_state = renew_ctrl_ff[BIT_RENEW_EXTRA] ? DRC_TW : DRC_IDLE;
         DRC_TW:   nxt_state = DRC_IDLE;
         default:  nxt_state = DRC_IDLE;
      endcase
   end

   always_ff @(posedge I_CLOCK) begin
      if (I_SYS_RST) begin
         state_ff <= DRC_IDLE;
      end else begin
         state_ff <= nxt_state;
      end
   end

   logic done;
   assign done = (state_ff != DRC_IDLE) && (nxt_state == DRC_IDLE);

   // Address advances only on a finished cycle, not per request
   always_ff @(posedge I_CLOCK) begin
      if (I_SYS_RST) begin
         O_RENEW_ADDR <= RESET_RENEW_ADDR;
      end else if (done) begin
         O_RENEW_ADDR <= O_RENEW_ADDR + 8'h01;
      end
   end

   // Strobe and busy registered from next state
   always_ff @(posedge I_CLOCK) begin
      if (I_SYS_RST) begin
         O_RENEW_STROBE_N <= 1'b1;
         O_RENEW_BUSY     <= 1'b0;
         O_IGNORE_WAITS   <= 1'b0;
      end else begin
         O_RENEW_STROBE_N <= (nxt_state == DRC_IDLE);
         O_RENEW_BUSY     <= (nxt_state != DRC_IDLE);
         O_IGNORE_WAITS   <= (nxt_state != DRC_IDLE)
                             || ((I_IO_WR || I_IO_RD) && is_internal(I_IO_ADDR));
      end
   end

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   property p_strobe_len;
      @(posedge I_CLOCK) disable iff (I_SYS_RST)
      $fell(O_RENEW_STROBE_N) |-> !O_RENEW_STROBE_N [*2] ##1
         (O_RENEW_STROBE_N or (!O_RENEW_STROBE_N ##1 O_RENEW_STROBE_N));
   endproperty
   a_strobe_len: assert property (p_strobe_len) else $error("bad strobe length");

   property p_addr_step;
      @(posedge I_CLOCK) disable iff (I_SYS_RST)
      $rose(O_RENEW_STROBE_N) |-> O_RENEW_ADDR == $past(O_RENEW_ADDR) + 8'h01;
   endproperty
   a_addr_step: assert property (p_addr_step) else $error("address did not step");

   property p_addr_hold;
      @(posedge I_CLOCK) disable iff (I_SYS_RST)
      !O_RENEW_STROBE_N |-> $stable(O_RENEW_ADDR);
   endproperty
   a_addr_hold: assert property (p_addr_hold) else $error("address moved mid cycle");

   property p_off;
      @(posedge I_CLOCK) disable iff (I_SYS_RST)
      !renew_ctrl_ff[BIT_RENEW_ON] && state_ff == DRC_IDLE |=> O_RENEW_STROBE_N;
   endproperty
   a_off: assert property (p_off) else $error("refresh while disabled");

   property p_start_allowed;
      @(posedge I_CLOCK) disable iff (I_SYS_RST)
      state_ff == DRC_IDLE && !allow |=> O_RENEW_STROBE_N;
   endproperty
   a_start_allowed: assert property (p_start_allowed) else $error("start not allowed");

   property p_pending_start;
      @(posedge I_CLOCK) disable iff (I_SYS_RST)
      pending_ff && allow && state_ff == DRC_IDLE |=> !O_RENEW_STROBE_N;
   endproperty
   a_pending_start: assert property (p_pending_start) else $error("pending not served");

   property p_tick_period;
      @(posedge I_CLOCK) disable iff (I_SYS_RST)
      tick |=> timer_ff == 8'h00 ##247 tick;
   endproperty
   a_tick_period: assert property (p_tick_period) else $error("interval not 248");

   property p_internal;
      @(posedge I_CLOCK) disable iff (I_SYS_RST)
      I_IO_WR && I_IO_ADDR[15:8] != 8'h00 |=> !O_IO_INTERNAL;
   endproperty
   a_internal: assert property (p_internal) else $error("upper address decoded");

   property p_rdata;
      @(posedge I_CLOCK) disable iff (I_SYS_RST)
      I_IO_RD && hit_ctrl |=> O_IO_RDATA == $past(renew_ctrl_ff);
   endproperty
   a_rdata: assert property (p_rdata) else $error("read returned external data");
endmodule // drc_refresh

// ---- logic/drc_pkg.sv ----
// Package: constants for the DRAM refresh controller
package drc_pkg;
   // ----------------------------------------
   // Register map
   // ----------------------------------------
   localparam logic [7:0] ADDR_RENEW_CONTROL = 8'h36;
   localparam int         BIT_RENEW_ON       = 7;
   localparam int         BIT_RENEW_EXTRA    = 6;
   localparam logic [7:0] RESET_RENEW_CTRL   = 8'hC0;
   localparam logic [7:0] RESET_RENEW_ADDR   = 8'h00;
   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int         CLK_PERIOD_NS      = 10;
   localparam logic [7:0] RENEW_INTERVAL_CYC = 8'hF8;  // 248 clocks
   localparam logic [1:0] CYC_LEN_SHORT      = 2'h2;
   localparam logic [1:0] CYC_LEN_LONG       = 2'h3;
   // ----------------------------------------
   // States
   // ----------------------------------------
   typedef enum logic [1:0] {DRC_IDLE, DRC_T1, DRC_T2, DRC_TW} drc_state_t;
endpackage : drc_pkg

// ---- tb/drc_dram_model.sv ----
// Dynamic RAM stand-in: watches refresh cycles, answers reads
`timescale 1ns/1ps
module drc_dram_model (
   input  wire logic       i_clk,
   input  wire logic [7:0] i_row,
   input  wire logic       i_strobe_n,
   output logic [7:0]      o_rdata
);
   logic       prev_ff = 1'b1;
   logic [7:0] row_ff = 8'h00;
   int         low_len = 0;
   int         last_len = 0;
   int         n_ref = 0;
   longint     t_fall = 0;
   logic [7:0] byte_ff = 8'h5A;
   // Byte changes every cycle, so a stale value never passes
   always @(posedge i_clk) byte_ff <= byte_ff + 8'h37;
   assign o_rdata = byte_ff;
   // Row latched at strobe fall; low time counted until it rises
   always @(posedge i_clk) begin
      prev_ff <= i_strobe_n;
      if (!i_strobe_n) begin
         low_len <= low_len + 1;
         if (prev_ff) begin
            t_fall <= $time;
            row_ff <= i_row;
         end
      end else if (!prev_ff) begin
         last_len <= low_len;
         n_ref <= n_ref + 1;
         low_len <= 0;
      end
   end
endmodule // drc_dram_model

// ---- tb/tb_dram_refresh_controller.sv ----
// Self-checking bench for the refresh controller
`timescale 1ns/1ps
module tb_dram_refresh_controller;
   import drc_pkg::*;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic [15:0] addr = 16'h0000;
   logic [7:0]  wdata = 8'h00;
   logic        wr = 1'b0;
   logic        rd = 1'b0;
   logic        idle = 1'b1;
   logic        wait_n = 1'b1;
   logic        hold_n = 1'b1;
   logic [7:0]  ext, rdata, row, d, e, r0;
   logic        intl, ign, strobe_n, busy, f, g;
   int          error_cnt = 0;
   int          n_compared = 0;
   int          cyc = 0;
   longint      t0, nxt;
   // Clock, 10 ns period
   always #5 clk = ~clk;
   drc_refresh i_drc_refresh (.I_CLOCK(clk), .I_SYS_RST(rst), .I_IO_ADDR(addr),
      .I_IO_WR(wr), .I_IO_RD(rd), .I_IO_WDATA(wdata), .I_EXT_RDATA(ext),
      .I_BUS_IDLE(idle), .I_WAIT_N(wait_n), .I_BUS_HOLD_REQUEST_N(hold_n),
      .O_IO_RDATA(rdata), .O_IO_INTERNAL(intl), .O_IGNORE_WAITS(ign),
      .O_RENEW_ADDR(row), .O_RENEW_STROBE_N(strobe_n), .O_RENEW_BUSY(busy));
   drc_dram_model i_drc_dram_model (.i_clk(clk), .i_row(row), .i_strobe_n(strobe_n),
      .o_rdata(ext));
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         error_cnt++;
         $display("BAD %0t got %0h want %0h", $time, seen, exp);
      end
   endtask
   task automatic wr_reg(input logic [15:0] a, input logic [7:0] v);
      @(posedge clk);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   // Far-side byte noted before the taking edge, answer one cycle later
   task automatic rd_reg(input logic [15:0] a);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      #1 e = ext;
      @(posedge clk);
      rd <= 1'b0;
      #1 d = rdata;
      f = intl;
      g = ign;
   endtask
   task automatic wait_ref(input int lim);
      int n0;
      n0 = i_drc_dram_model.n_ref;
      repeat (lim) begin
         @(posedge clk);
         #1;
         if (i_drc_dram_model.n_ref != n0) return;
      end
      chk(1'b0, 1'b1);
   endtask
   // Ends on an edge so the caller may drive by NBA right after
   task automatic quiet(input int lim);
      int n0;
      n0 = i_drc_dram_model.n_ref;
      repeat (lim) @(posedge clk);
      chk(i_drc_dram_model.n_ref, n0);
   endtask
   task automatic conclude();
      $display("Compared %0d, mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   // Hang guard, well above the expected run length
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 9000) begin
         error_cnt++;
         conclude();
      end
   end
   // Main sequence
   initial begin
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      rd_reg(16'h0036);
      chk(d, RESET_RENEW_CTRL);
      chk({f, g}, 2'b11);
      rd_reg(16'h1236);
      chk({d, f}, {e, 1'b0});
      wr_reg(16'h0036, 8'h7F);
      #1 chk({intl, ign}, 2'b11);
      wr_reg(16'h1236, 8'h00);
      #1 chk(intl, 1'b0);
      rd_reg(16'h0036);
      chk(d, 8'h40);
      $display("Test registers finished");
      wr_reg(16'h0036, 8'h80);
      wait_ref(600);
      chk(i_drc_dram_model.last_len, 2);
      wr_reg(16'h0036, 8'hC0);
      wait_ref(300);
      t0 = i_drc_dram_model.t_fall;
      r0 = i_drc_dram_model.row_ff;
      wait_ref(300);
      chk(i_drc_dram_model.t_fall - t0, 2480);
      chk(i_drc_dram_model.last_len, 3);
      chk(i_drc_dram_model.row_ff, 8'(r0 + 8'h01));
      wr_reg(16'h0036, 8'h00);
      quiet(600);
      chk(row, 8'(r0 + 8'h02));
      $display("Test timing finished");
      idle <= 1'b0;
      wr_reg(16'h0036, 8'h80);
      quiet(600);
      idle <= 1'b1;
      wait_ref(8);
      wr_reg(16'h0036, 8'hC0);
      wait_ref(300);
      t0 = i_drc_dram_model.t_fall;
      @(posedge clk);
      hold_n <= 1'b0;
      quiet(600);
      hold_n <= 1'b1;
      wait_ref(12);
      wait_ref(300);
      chk((i_drc_dram_model.t_fall - t0) % 2480, 0);
      $display("Test suppression finished");
      t0 = i_drc_dram_model.t_fall;
      nxt = t0 + 2480;
      while ($time + 10 < nxt) @(posedge clk);
      wait_n <= 1'b0;
      repeat (2) @(posedge clk);
      #1 chk({strobe_n, busy, ign}, 3'b011);
      wait_ref(8);
      chk(i_drc_dram_model.last_len, 3);
      quiet(300);
      wait_n <= 1'b1;
      wait_ref(12);
      $display("Test wait finished");
      conclude();
   end
endmodule // tb_dram_refresh_controller
